// ---- inc/ffx_consts.vh ----
// Register offsets, field positions, reset values and timing counts of the FIFO array host.
`ifndef FFX_CONSTS_VH
`define FFX_CONSTS_VH
`define FFX_ADDR_W 5
`define FFX_OFF_CTRL 5'h00
`define FFX_OFF_STATUS 5'h04
`define FFX_OFF_DATA_IN 5'h08
`define FFX_OFF_DATA_OUT 5'h0C
`define FFX_OFF_IRQ_STAT 5'h10
`define FFX_OFF_IRQ_EN 5'h14
`define FFX_OFF_IRQ_CLR 5'h18
`define FFX_CTRL_INIT 0
`define FFX_CTRL_PULL 1
`define FFX_ST_BUSY 0
`define FFX_ST_IN_READY 1
`define FFX_ST_OUT_VALID 2
`define FFX_ST_RX_VALID 3
`define FFX_ST_LEVEL_LSB 16
`define FFX_EV_INIT 0
`define FFX_EV_IN 1
`define FFX_EV_OUT 2
`define FFX_EV_REFUSED 3
`define FFX_EV_W 4
`define FFX_IRQ_EN_RESET 4'h0
`define FFX_WORDS_PER_SLICE 15
`define FFX_SLICE_BITS 4
`define FFX_PCLK_NS 5
`define FFX_INIT_LOW_NS 20
`define FFX_LOAD_HIGH_NS 5
`define FFX_INIT_CYC ((`FFX_INIT_LOW_NS + `FFX_PCLK_NS - 1) / `FFX_PCLK_NS)
`define FFX_LOAD_CYC ((`FFX_LOAD_HIGH_NS + `FFX_PCLK_NS - 1) / `FFX_PCLK_NS)
`endif

// ---- design/ffx_host.v ----
// Host controller that drives an expanded array of fall-through FIFO slices over APB.
//
// Behaviour
// - Vertical chain of n slices holds 15n+1 words of four bits.
// - Array of m rows by n columns holds 15m+1 words of 4n bits.
// - Host offers words only when last input full flag is high, reads on valid.
// - Row master grant is tied low; slaves take grant from previous full flag.
`timescale 1ns/1ps
`include "ffx_consts.vh"
module ffx_host #(
  parameter ROWS = 2,
  parameter COLS = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`FFX_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  output reg init_n,
  output reg word_load,
  output reg [4*COLS-1:0] array_data_in,
  output reg push_to_stack_n,
  output reg row_grant_in_n,
  output reg word_pull,
  output reg serial_pull_req_n,
  input wire input_full_n,
  input wire out_word_valid,
  input wire [4*COLS-1:0] array_data_out
);
  localparam DW = `FFX_SLICE_BITS * COLS;
  // Integer forms first, then cut on purpose to the widths the comparisons use.
  localparam integer CAPACITY_I = `FFX_WORDS_PER_SLICE * ROWS + 1;
  localparam integer INIT_CYC_I = `FFX_INIT_CYC;
  localparam integer LOAD_CYC_I = `FFX_LOAD_CYC;
  localparam [15:0] CAPACITY = CAPACITY_I[15:0];
  localparam [7:0] INIT_CYC = INIT_CYC_I[7:0];
  localparam [7:0] LOAD_CYC = LOAD_CYC_I[7:0];
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_INIT = 3'h1;
  localparam [2:0] S_INIT_WAIT = 3'h2;
  localparam [2:0] S_LOAD = 3'h3;
  localparam [2:0] S_PUSH = 3'h4;
  localparam [2:0] S_PULL = 3'h5;
  localparam [2:0] S_PULL_END = 3'h6;

  reg [2:0] state;
  reg [7:0] cnt;
  // The level counter is bookkeeping of the host; the slices report no count.
  reg [15:0] level;
  reg [DW-1:0] rx_word;
  reg rx_valid;
  reg [`FFX_EV_W-1:0] irq_stat;
  reg [`FFX_EV_W-1:0] irq_en;
  reg [`FFX_EV_W-1:0] ev;
  reg [`FFX_EV_W-1:0] next_irq_stat;
  reg addr_ok;

  // One address decode for every register strobe keeps the map in one place.
  function addr_hit;
    input [`FFX_ADDR_W-1:0] a;
    input [`FFX_ADDR_W-1:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  // Phase counter step; it saturates so a stalled array cannot wrap it into a short count.
  function [7:0] step_cnt;
    input [7:0] v;
    begin
      if (v == 8'hFF) begin
        step_cnt = v;
      end else begin
        step_cnt = v + 8'h01;
      end
    end
  endfunction

  // Fill level step: one word in or one word out.
  function [15:0] step_level;
    input [15:0] v;
    input up;
    begin
      if (up) begin
        step_level = v + 16'h0001;
      end else begin
        step_level = v - 16'h0001;
      end
    end
  endfunction

  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire busy = (state != S_IDLE);
  wire wr_ctrl = wr & addr_hit(paddr, `FFX_OFF_CTRL);
  wire wr_data = wr & addr_hit(paddr, `FFX_OFF_DATA_IN);
  wire rd_data = rd & addr_hit(paddr, `FFX_OFF_DATA_OUT);
  wire wr_irq_en = wr & addr_hit(paddr, `FFX_OFF_IRQ_EN);
  wire [`FFX_EV_W-1:0] clr_bits = (wr & addr_hit(paddr, `FFX_OFF_IRQ_CLR)) ?
    pwdata[`FFX_EV_W-1:0] : {`FFX_EV_W{1'b0}};
  // A word is offered only while the array can take it and there is room in it.
  wire can_load = ~busy & input_full_n & (level < CAPACITY);
  wire can_pull = ~busy & (level != 16'h0000) & ~rx_valid;
  wire start_init = wr_ctrl & pwdata[`FFX_CTRL_INIT] & ~busy;
  wire start_pull = wr_ctrl & ~pwdata[`FFX_CTRL_INIT] & pwdata[`FFX_CTRL_PULL] & can_pull;
  // Each refusal is named so the refused-command event can be traced to its cause.
  wire refuse_load = wr_data & ~can_load;
  wire refuse_init = wr_ctrl & pwdata[`FFX_CTRL_INIT] & busy;
  wire refuse_pull = wr_ctrl & ~pwdata[`FFX_CTRL_INIT] & pwdata[`FFX_CTRL_PULL] & ~can_pull;
  wire refused = refuse_load | refuse_init | refuse_pull;

  always @* begin
    case (paddr)
      `FFX_OFF_CTRL, `FFX_OFF_STATUS, `FFX_OFF_DATA_IN, `FFX_OFF_DATA_OUT,
      `FFX_OFF_IRQ_STAT, `FFX_OFF_IRQ_EN, `FFX_OFF_IRQ_CLR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Sticky status: an event in the same cycle as its clear survives.
  always @* begin
    next_irq_stat = (irq_stat & ~clr_bits) | ev;
  end

  // APB slave: zero wait states; read data is captured in the setup cycle.
  // Capturing at setup lets prdata stand through the whole access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_en <= `FFX_IRQ_EN_RESET;
      irq_stat <= {`FFX_EV_W{1'b0}};
      irq <= 1'b0;
    end else begin
      pready <= 1'b1;
      irq_stat <= next_irq_stat;
      // The interrupt follows the next status value, so it rises with the sticky bit.
      irq <= |(next_irq_stat & irq_en);
      if (wr_irq_en) begin
        irq_en <= pwdata[`FFX_EV_W-1:0];
      end
      if (setup) begin
        pslverr <= ~addr_ok;
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          case (paddr)
            `FFX_OFF_STATUS: begin
              prdata[`FFX_ST_BUSY] <= busy;
              prdata[`FFX_ST_IN_READY] <= can_load;
              prdata[`FFX_ST_OUT_VALID] <= out_word_valid;
              prdata[`FFX_ST_RX_VALID] <= rx_valid;
              prdata[31:`FFX_ST_LEVEL_LSB] <= level;
            end
            `FFX_OFF_DATA_OUT: begin
              prdata[DW-1:0] <= rx_word;
            end
            `FFX_OFF_IRQ_STAT: begin
              prdata[`FFX_EV_W-1:0] <= irq_stat;
            end
            `FFX_OFF_IRQ_EN: begin
              prdata[`FFX_EV_W-1:0] <= irq_en;
            end
            default: begin
              prdata <= 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  // Array sequencer. After reset it holds the master reset low, waits for the
  // row to report empty, and then serves one command at a time: a load that
  // ends in a push into the stack, or a pull that ends when valid drops.
  // There is no timeout on the array flags; software sees a hang as busy.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_INIT;
      cnt <= 8'h00;
      level <= 16'h0000;
      rx_word <= {DW{1'b0}};
      rx_valid <= 1'b0;
      ev <= {`FFX_EV_W{1'b0}};
      init_n <= 1'b0;
      word_load <= 1'b0;
      array_data_in <= {DW{1'b0}};
      push_to_stack_n <= 1'b1;
      row_grant_in_n <= 1'b0;
      word_pull <= 1'b0;
      serial_pull_req_n <= 1'b1;
    end else begin
      ev <= {`FFX_EV_W{1'b0}};
      ev[`FFX_EV_REFUSED] <= refused;
      // The row master grant never leaves ground; slaves are chained by wiring.
      row_grant_in_n <= 1'b0;
      // Parallel extraction only; the serial request stays idle.
      serial_pull_req_n <= 1'b1;
      if (rd_data) begin
        rx_valid <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (start_init) begin
            init_n <= 1'b0;
            cnt <= 8'h00;
            state <= S_INIT;
          end else if (wr_data & can_load) begin
            array_data_in <= pwdata[DW-1:0];
            word_load <= 1'b1;
            cnt <= 8'h00;
            state <= S_LOAD;
          end else if (start_pull) begin
            word_pull <= 1'b1;
            state <= S_PULL;
          end
        end
        S_INIT: begin
          // Push stays high so no request-initialization is latched during reset.
          if (cnt >= INIT_CYC - 8'h01) begin
            init_n <= 1'b1;
            state <= S_INIT_WAIT;
          end else begin
            cnt <= step_cnt(cnt);
          end
        end
        S_INIT_WAIT: begin
          // The array is ready once the last full flag reads high after reset.
          if (input_full_n) begin
            level <= 16'h0000;
            rx_valid <= 1'b0;
            ev[`FFX_EV_INIT] <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_LOAD: begin
          // Hold the load pulse its least width and until the whole row is full.
          if (cnt < LOAD_CYC) begin
            cnt <= step_cnt(cnt);
          end
          if ((cnt >= LOAD_CYC - 8'h01) & ~input_full_n) begin
            word_load <= 1'b0;
            push_to_stack_n <= 1'b0;
            state <= S_PUSH;
          end
        end
        S_PUSH: begin
          // Load is already low, so the slices may reinitialize; the word is in
          // only when the last slave in the row reports empty again.
          if (input_full_n) begin
            push_to_stack_n <= 1'b1;
            level <= step_level(level, 1'b1);
            ev[`FFX_EV_IN] <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_PULL: begin
          // Data is taken only when the last slave of the output row is valid.
          if (out_word_valid) begin
            rx_word <= array_data_out;
            rx_valid <= 1'b1;
            word_pull <= 1'b0;
            state <= S_PULL_END;
          end
        end
        S_PULL_END: begin
          // Wait for valid to drop so the next pull cannot see a stale flag.
          if (!out_word_valid) begin
            level <= step_level(level, 1'b0);
            ev[`FFX_EV_OUT] <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- testbench/ffx_host_asserts.sv ----
// Checker for the host side of the slice-array handshake.
`timescale 1ns/1ps
module ffx_host_asserts #(
  parameter COLS = 4
) (
  input logic pclk,
  input logic presetn,
  input logic init_n,
  input logic word_load,
  input logic [4*COLS-1:0] array_data_in,
  input logic push_to_stack_n,
  input logic row_grant_in_n,
  input logic word_pull,
  input logic serial_pull_req_n,
  input logic input_full_n,
  input logic out_word_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_load_end; $fell(word_load); endsequence
  sequence s_push_done; !push_to_stack_n && input_full_n; endsequence
  property p_grant; row_grant_in_n == 1'b0; endproperty
  a_grant: assert property (p_grant) else $error("grant not low");
  property p_load; $rose(word_load) |-> $past(input_full_n) && init_n; endproperty
  a_load: assert property (p_load) else $error("load while full");
  property p_push; s_load_end |-> !push_to_stack_n; endproperty
  a_push: assert property (p_push) else $error("no push after load");
  property p_push_rel; s_push_done |=> push_to_stack_n; endproperty
  a_push_rel: assert property (p_push_rel) else $error("push held");
  property p_data; word_load && $past(word_load) |-> $stable(array_data_in); endproperty
  a_data: assert property (p_data) else $error("data moved");
  property p_pull; word_pull && out_word_valid |=> !word_pull; endproperty
  a_pull: assert property (p_pull) else $error("pull held");
  property p_excl; !(word_load && (word_pull || !push_to_stack_n)); endproperty
  a_excl: assert property (p_excl) else $error("overlap");
  property p_init; $rose(presetn) |-> !init_n [*4]; endproperty
  a_init: assert property (p_init) else $error("init short");
  property p_serial; serial_pull_req_n == 1'b1; endproperty
  a_serial: assert property (p_serial) else $error("serial pull requested");
endmodule
bind ffx_host ffx_host_asserts #(.COLS(COLS)) chk_u (.pclk(pclk), .presetn(presetn),
  .init_n(init_n), .word_load(word_load), .array_data_in(array_data_in),
  .push_to_stack_n(push_to_stack_n), .row_grant_in_n(row_grant_in_n),
  .word_pull(word_pull), .serial_pull_req_n(serial_pull_req_n),
  .input_full_n(input_full_n), .out_word_valid(out_word_valid));

// ---- testbench/ffx_array_model.sv ----
// Behavioural model of the slice array as seen through its last-slave flags.
`timescale 1ns/1ps
module ffx_array_model (
  input logic pclk,
  input logic init_n,
  input logic word_load,
  input logic [15:0] array_data_in,
  input logic push_to_stack_n,
  input logic row_grant_in_n,
  input logic word_pull,
  input logic serial_pull_req_n,
  output logic input_full_n,
  output logic out_word_valid,
  output logic [15:0] array_data_out
);
  logic [15:0] mem[$];
  logic [15:0] ireg, q;
  logic lead, full, req, done;
  logic [1:0] t;
  assign input_full_n = ~full;
  // Released outputs show the inverse so a late sample cannot pass by luck.
  assign array_data_out = out_word_valid ? q : ~q;
  always @(posedge pclk or negedge init_n) begin
    if (!init_n) begin
      full <= 1'b0;
      out_word_valid <= 1'b0;
      done <= 1'b0;
      req <= 1'b0;
      t <= 2'd0;
      q <= 16'h0000;
      mem.delete();
      lead <= !row_grant_in_n;
    end else begin
      t <= t + 2'd1;
      if (word_load && !full) begin
        full <= 1'b1;
        ireg <= array_data_in;
      end
      if (!push_to_stack_n && full && !req && mem.size() < 31) begin
        mem.push_back(ireg);
        req <= 1'b1;
      end
      if (req && !word_load && (lead || !row_grant_in_n) && t[0]) begin
        full <= 1'b0;
        req <= 1'b0;
      end
      if ((word_pull || !serial_pull_req_n) && !done && mem.size() > 0 && (lead || t[1])) begin
        q <= mem.pop_front();
        out_word_valid <= 1'b1;
        done <= 1'b1;
      end
      if (!word_pull && serial_pull_req_n) begin
        out_word_valid <= 1'b0;
        done <= 1'b0;
      end
    end
  end
endmodule

// ---- testbench/ffx_host_test.sv ----
// Testbench driving the FIFO array host over APB against the array model.
`timescale 1ns/1ps
`include "ffx_consts.vh"
module ffx_host_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, init_n, word_load, push_to_stack_n, row_grant_in_n;
  logic word_pull, serial_pull_req_n, input_full_n, out_word_valid;
  logic [15:0] array_data_in, array_data_out, wd;
  int n_errors = 0, n_tests = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  ffx_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .init_n(init_n), .word_load(word_load),
    .array_data_in(array_data_in), .push_to_stack_n(push_to_stack_n),
    .row_grant_in_n(row_grant_in_n), .word_pull(word_pull),
    .serial_pull_req_n(serial_pull_req_n), .input_full_n(input_full_n),
    .out_word_valid(out_word_valid), .array_data_out(array_data_out));
  ffx_array_model arr_u (.pclk(pclk), .init_n(init_n), .word_load(word_load),
    .array_data_in(array_data_in), .push_to_stack_n(push_to_stack_n),
    .row_grant_in_n(row_grant_in_n), .word_pull(word_pull),
    .serial_pull_req_n(serial_pull_req_n), .input_full_n(input_full_n),
    .out_word_valid(out_word_valid), .array_data_out(array_data_out));
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict;
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  // Polls busy with a bound so a stuck sequencer shows up as a mismatch.
  task idle;
    repeat (100) begin
      apb(1'b0, `FFX_OFF_STATUS, 32'h0);
      if (r[0] === 1'b0) return;
    end
    n_errors++;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    idle;
    chk("status_idle", 32'h00000002, r);
    apb(1'b0, `FFX_OFF_IRQ_STAT, 32'h0); chk("irq_stat", 32'h1, r);
    apb(1'b1, `FFX_OFF_IRQ_CLR, 32'hF);
    apb(1'b1, `FFX_OFF_CTRL, 32'h2); idle;
    apb(1'b0, `FFX_OFF_IRQ_STAT, 32'h0); chk("empty_pull", 32'h8, r);
    apb(1'b1, `FFX_OFF_IRQ_CLR, 32'hF);
    apb(1'b0, `FFX_OFF_IRQ_EN, 32'h0); chk("irq_en", 32'h0, r);
    apb(1'b1, `FFX_OFF_IRQ_EN, 32'h2);
    for (int i = 0; i < 31; i++) begin
      wd = 16'hA5C3 ^ (16'(i) * 16'h0111);
      apb(1'b1, `FFX_OFF_DATA_IN, {16'h0000, wd}); idle;
    end
    chk("irq", 32'h1, irq);
    apb(1'b0, `FFX_OFF_STATUS, 32'h0); chk("level", 32'd31, r[31:16]);
    chk("full_status", 32'h00000000, r & 32'h0000FFFF);
    apb(1'b1, `FFX_OFF_DATA_IN, 32'h0); idle;
    apb(1'b0, `FFX_OFF_IRQ_STAT, 32'h0); chk("over", 32'h8, r & 32'h8);
    apb(1'b1, `FFX_OFF_IRQ_CLR, 32'hF);
    apb(1'b0, `FFX_OFF_STATUS, 32'h0); chk("irq_clr", 32'h0, irq);
    for (int i = 0; i < 31; i++) begin
      wd = 16'hA5C3 ^ (16'(i) * 16'h0111);
      apb(1'b1, `FFX_OFF_CTRL, 32'h2); idle;
      chk("pull_status", {16'(30 - i), 16'h000A}, r);
      apb(1'b0, `FFX_OFF_DATA_OUT, 32'h0); chk("word", wd, r[15:0]);
    end
    apb(1'b0, `FFX_OFF_STATUS, 32'h0); chk("drained", 32'h0, r[31:16]);
    apb(1'b0, 5'h1C, 32'h0); chk("pslverr", 32'h1, e);
    // A second reset in mid-run must rebuild row mastership and redo the init.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    idle;
    chk("reinit_status", 32'h00000002, r);
    apb(1'b0, `FFX_OFF_IRQ_STAT, 32'h0);
    chk("reinit_irq_stat", 32'h00000001, r);
    chk("reinit_irq", 32'h0, irq);
    give_verdict;
  end
endmodule
